// ---- logic/ibrm_consts.svh ----
// constants for the isa buffer and request multiplexer
`ifndef IBRM_CONSTS_SVH
`define IBRM_CONSTS_SVH
`define IBRM_NUM_SLOTS     4
`define IBRM_SLOT_W        2
`define IBRM_ACK_W         3
`define IBRM_NUM_DACK      7
`define IBRM_DACK_IDLE     7'h7f
`define IBRM_STRAP_BIT_A   4
`define IBRM_STRAP_BIT_B   1
`define IBRM_BYTE_RST      8'h00
`endif

// ---- logic/ibrm_pkg.sv ----
// types for the isa buffer and request multiplexer
package ibrm_pkg;
    typedef logic [3:0] ibrm_slot_vec_t;
    typedef logic [6:0] ibrm_dack_t;
endpackage : ibrm_pkg

// ---- logic/ibrm_mux_if.sv ----
// interface between the top and the request multiplexer
`timescale 1ns/1ps
interface ibrm_mux_if;
    logic [3:0] src0;
    logic [3:0] src1;
    logic [3:0] src2;
    logic [3:0] src3;
    logic [1:0] slot;
    logic [3:0] req_mux;
    modport top (output src0, output src1, output src2, output src3,
                 output slot, input req_mux);
    modport mux (input src0, input src1, input src2, input src3,
                 input slot, output req_mux);
endinterface : ibrm_mux_if

// ---- logic/ibrm_req_mux.sv ----
// four-slot time-shared request multiplexer
`timescale 1ns/1ps
module ibrm_req_mux (
    input  wire logic clk,
    input  wire logic nrst,
    ibrm_mux_if.mux   mif
);
    logic [3:0] req_mux_r;

    function automatic logic pick(input logic [3:0] v, input logic [1:0] s);
        pick = v[s];
    endfunction : pick

    // one registered bit per line, slot order fixed
    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_mux_r <= 4'h0;
        end else begin
            req_mux_r[0] <= pick(mif.src0, mif.slot);
            req_mux_r[1] <= pick(mif.src1, mif.slot);
            req_mux_r[2] <= pick(mif.src2, mif.slot);
            req_mux_r[3] <= pick(mif.src3, mif.slot);
        end
    end
    assign mif.req_mux = req_mux_r;

    property p_slot_follow;
        @(posedge clk) disable iff (!nrst)
        nrst |=> req_mux_r[0] == $past(mif.src0[mif.slot]);
    endproperty
    a_slot_follow: assert property (p_slot_follow)
        else $error("req mux 0 not from selected slot");
    property p_mux3;
        @(posedge clk) disable iff (!nrst)
        nrst |=> req_mux_r[3] == $past(mif.src3[mif.slot]);
    endproperty
    a_mux3: assert property (p_mux3)
        else $error("req mux 3 not from selected slot");
endmodule : ibrm_req_mux

// ---- logic/ibrm_top.sv ----
// isa bus buffer and request multiplexer, notebook mode strapped at reset release
`timescale 1ns/1ps
`include "ibrm_consts.svh"
module ibrm_top (
    input  wire logic       clk,
    input  wire logic       nrst,
    output logic            bus_reset_out,
    input  wire logic [3:0] irq_a,
    input  wire logic [3:0] irq_b,
    input  wire logic       rtc_irq_n,
    input  wire logic       irq15,
    input  wire logic [5:0] dma_req,
    input  wire logic       kbd_clock_phase,
    input  wire logic       kbd_clock_half,
    output logic [3:0]      req_mux,
    input  wire logic [2:0] encoded_ack_code,
    output logic [6:0]      dack_n,
    input  wire logic [7:0] buffer_in,
    output logic [7:0]      buffer_out,
    output logic            buffer_out_oe,
    output logic            buffer_out0_inv,
    input  wire logic       buffer_float_n,
    input  wire logic       buffer_latch,
    input  wire logic       rom_select_n,
    input  wire logic       rom_clock_cmd_select_n,
    input  wire logic       atbus_float_n,
    input  wire logic       atbus_cycle_flag,
    input  wire logic       mem_read_n,
    input  wire logic       mem_write_n,
    output logic            smem_read_n,
    output logic            smem_write_n,
    output logic            smem_oe,
    input  wire logic [7:0] sd_in,
    output logic [7:0]      sd_out,
    output logic            sd_oe,
    input  wire logic [7:0] peripheral_data_bus_in,
    output logic [7:0]      peripheral_data_bus_out,
    output logic            peripheral_data_bus_oe,
    input  wire logic       clock_addr_strobe,
    output logic [7:0]      clock_addr,
    input  wire logic       dram_we_or_kbd_select_n,
    input  wire logic       addr_enable,
    output logic            kbd_ctrl_select_n,
    output logic            nb_mode
);
    // irq_a = {irq7,irq3,irq1,irq14 order below}; see mapping in slot build
    // dma_req = {drq7,drq6,drq5,drq3,drq1,drq0}

    // ------------------------------------------------------------
    // reset drive and strap capture
    // ------------------------------------------------------------
    assign bus_reset_out = ~nrst;

    logic nb_mode_r;
    logic in_reset_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            in_reset_r <= 1'b1;
            nb_mode_r  <= 1'b0;
        end else if (in_reset_r) begin
            in_reset_r <= 1'b0;
            nb_mode_r  <= ~peripheral_data_bus_in[`IBRM_STRAP_BIT_A] &
                          ~peripheral_data_bus_in[`IBRM_STRAP_BIT_B];
        end
    end
    assign nb_mode = nb_mode_r;

    // ------------------------------------------------------------
    // request multiplexing
    // ------------------------------------------------------------
    ibrm_mux_if mif ();
    // slot number from keyboard clock phases
    assign mif.slot = {kbd_clock_half, kbd_clock_phase};
    // irq_a = {irq7,irq3,irq1,irq14}, irq_b = {irq12,irq10,irq6,irq4}
    assign mif.src0 = {irq_a[0], irq_a[3], irq_a[2], irq_a[1]};
    assign mif.src1 = {irq_b[3], ~rtc_irq_n, irq_b[1], irq_b[0]};
    assign mif.src2 = {dma_req[0] | dma_req[3], 1'b0, irq15,
                       irq_b[2]};
    assign mif.src3 = {dma_req[5], dma_req[4], dma_req[2],
                       dma_req[1]};

    ibrm_req_mux ibrm_req_mux_inst (
        .clk  (clk),
        .nrst (nrst),
        .mif  (mif)
    );
    assign req_mux = mif.req_mux;

    // ------------------------------------------------------------
    // acknowledge decode
    // ------------------------------------------------------------
    function automatic ibrm_pkg::ibrm_dack_t dack_dec(input logic [2:0] c);
        dack_dec = `IBRM_DACK_IDLE;
        unique case (c)
            3'h0: dack_dec[0] = 1'b0;
            3'h1: dack_dec[1] = 1'b0;
            3'h2: dack_dec[2] = 1'b0;
            3'h3: dack_dec[3] = 1'b0;
            3'h5: dack_dec[4] = 1'b0;
            3'h6: dack_dec[5] = 1'b0;
            3'h7: dack_dec[6] = 1'b0;
            default: dack_dec = `IBRM_DACK_IDLE;
        endcase
    endfunction : dack_dec

    logic [6:0] dack_n_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dack_n_r <= `IBRM_DACK_IDLE;
        end else begin
            dack_n_r <= dack_dec(encoded_ack_code);
        end
    end
    assign dack_n = dack_n_r;

    // ------------------------------------------------------------
    // data buffer
    // ------------------------------------------------------------
    logic [7:0] buf_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            buf_r <= `IBRM_BYTE_RST;
        end else if (buffer_latch) begin
            buf_r <= buffer_in;
        end
    end
    assign buffer_out      = buf_r;
    assign buffer_out_oe   = buffer_float_n;
    assign buffer_out0_inv = ~buf_r[0];

    // ------------------------------------------------------------
    // sd / xd path and memory strobes
    // ------------------------------------------------------------
    logic [7:0] sd_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sd_r <= `IBRM_BYTE_RST;
        end else begin
            sd_r <= peripheral_data_bus_in;
        end
    end
    assign sd_out = sd_r;
    assign sd_oe  = ~rom_select_n & atbus_float_n & nrst;
    assign peripheral_data_bus_out = `IBRM_BYTE_RST;
    assign peripheral_data_bus_oe  = 1'b0;

    logic smr_r;
    logic smw_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            smr_r <= 1'b1;
            smw_r <= 1'b1;
        end else begin
            smr_r <= mem_read_n;
            smw_r <= mem_write_n;
        end
    end
    assign smem_read_n  = smr_r;
    assign smem_write_n = smw_r;
    assign smem_oe      = atbus_float_n;

    // ------------------------------------------------------------
    // clock address latch and keyboard select
    // ------------------------------------------------------------
    logic cas_d_r;
    logic [7:0] caddr_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cas_d_r <= 1'b0;
            caddr_r <= `IBRM_BYTE_RST;
        end else begin
            cas_d_r <= clock_addr_strobe;
            if (cas_d_r && !clock_addr_strobe) begin
                caddr_r <= peripheral_data_bus_in;
            end
        end
    end
    assign clock_addr = caddr_r;

    logic kcs_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            kcs_r <= 1'b1;
        end else begin
            kcs_r <= dram_we_or_kbd_select_n | addr_enable;
        end
    end
    assign kbd_ctrl_select_n = kcs_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_rst;
        @(posedge clk) bus_reset_out == !nrst;
    endproperty
    a_rst: assert property (p_rst)
        else $error("bus reset not inverse of reset");
    property p_float;
        @(posedge clk) disable iff (!nrst) !buffer_float_n |-> !buffer_out_oe;
    endproperty
    a_float: assert property (p_float)
        else $error("buffer driven while floated");
    property p_at;
        @(posedge clk) disable iff (!nrst)
        !atbus_float_n |-> !smem_oe && !sd_oe;
    endproperty
    a_at: assert property (p_at)
        else $error("at bus driven while floated");
    property p_inv;
        @(posedge clk) buffer_out0_inv != buffer_out[0];
    endproperty
    a_inv: assert property (p_inv)
        else $error("inverted bit 0 wrong");
    property p_dack;
        @(posedge clk) disable iff (!nrst)
        encoded_ack_code == 3'h4 |=> dack_n == `IBRM_DACK_IDLE;
    endproperty
    a_dack: assert property (p_dack)
        else $error("ack asserted on invalid code");
    property p_dack1;
        @(posedge clk) disable iff (!nrst)
        nrst && encoded_ack_code == 3'h0
        |=> $countones(~dack_n) == 1 && !dack_n[0];
    endproperty
    a_dack1: assert property (p_dack1)
        else $error("ack channel 0 not alone");
    property p_dack5;
        @(posedge clk) disable iff (!nrst)
        nrst && encoded_ack_code == 3'h5 |=> dack_n == 7'h6f;
    endproperty
    a_dack5: assert property (p_dack5)
        else $error("ack channel 5 not alone");
    property p_dack7;
        @(posedge clk) disable iff (!nrst)
        nrst && encoded_ack_code == 3'h7 |=> dack_n == 7'h3f;
    endproperty
    a_dack7: assert property (p_dack7)
        else $error("ack channel 7 not alone");
    property p_rom;
        @(posedge clk) disable iff (!nrst)
        nrst && !rom_select_n && atbus_float_n
        |=> sd_out == $past(peripheral_data_bus_in);
    endproperty
    a_rom: assert property (p_rom)
        else $error("rom data not passed");
    property p_kcs;
        @(posedge clk) disable iff (!nrst) addr_enable |=> kbd_ctrl_select_n;
    endproperty
    a_kcs: assert property (p_kcs)
        else $error("kbd select without address enable");
    property p_latch;
        @(posedge clk) disable iff (!nrst)
        nrst && !buffer_latch |=> $stable(buffer_out);
    endproperty
    a_latch: assert property (p_latch)
        else $error("buffer changed without latch");
    property p_strap;
        @(posedge clk) disable iff (!nrst)
        nrst && $past(!nrst) |=> nb_mode == $past(
            !peripheral_data_bus_in[`IBRM_STRAP_BIT_A] &&
            !peripheral_data_bus_in[`IBRM_STRAP_BIT_B]);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap not captured at reset release");
    property p_nbhold;
        @(posedge clk) disable iff (!nrst)
        nrst && $past(nrst) |=> $stable(nb_mode);
    endproperty
    a_nbhold: assert property (p_nbhold)
        else $error("configuration changed outside reset");
    property p_cas;
        @(posedge clk) disable iff (!nrst)
        nrst && $past(nrst) && $fell(clock_addr_strobe)
        |=> clock_addr == $past(peripheral_data_bus_in);
    endproperty
    a_cas: assert property (p_cas)
        else $error("address not latched on strobe fall");
    property p_smem;
        @(posedge clk) disable iff (!nrst)
        nrst |=> smem_read_n == $past(mem_read_n) &&
                 smem_write_n == $past(mem_write_n);
    endproperty
    a_smem: assert property (p_smem)
        else $error("memory strobe not passed through");
    c_ack: cover property (@(posedge clk) dack_n[6] == 1'b0);
    c_rom: cover property (@(posedge clk) sd_oe);
    c_cas: cover property (@(posedge clk) $fell(clock_addr_strobe));
    c_nb: cover property (@(posedge clk) nb_mode);
    c_hold: cover property (@(posedge clk) nrst && !buffer_latch);
endmodule : ibrm_top

// ---- test/ibrm_chipset_model.sv ----
// chipset side: slot phases, encoded acknowledge and rom/clock select
`timescale 1ns/1ps
module ibrm_chipset_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [1:0] slot_cmd,
    input  wire logic [2:0] ack_cmd,
    output logic            kbd_clock_phase,
    output logic            kbd_clock_half,
    output logic [2:0]      encoded_ack_code,
    output logic            rom_clock_cmd_select_n
);
    // slots follow {half,phase}, the same order used to demultiplex
    always_ff @(posedge clk) begin
        if (!nrst) begin
            {kbd_clock_half, kbd_clock_phase} <= 2'h0;
        end else begin
            {kbd_clock_half, kbd_clock_phase} <= slot_cmd;
        end
    end
    always_ff @(posedge clk) begin
        encoded_ack_code <= nrst ? ack_cmd : 3'h4;
    end
    always_ff @(posedge clk) begin
        rom_clock_cmd_select_n <= !nrst;
    end
endmodule : ibrm_chipset_model

// ---- test/tb.sv ----
// self-checking testbench for the isa buffer and request multiplexer
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, nrst = 1'b0, rtc_irq_n = 1'b1, cyc = 1'b0, irq15 = 1'b0;
    logic [3:0] irq_a = 4'h0, irq_b = 4'h0;
    logic [5:0] dma_req = 6'h00;
    logic [1:0] slot_cmd = 2'h0;
    logic [2:0] ack_cmd = 3'h4, encoded_ack_code;
    logic [7:0] buffer_in = 8'h00, sd_in = 8'h00, xd = 8'h00;
    logic buffer_float_n = 1'b1, buffer_latch = 1'b1, rom_select_n = 1'b1;
    logic atbus_float_n = 1'b1, mem_read_n = 1'b1, mem_write_n = 1'b1;
    logic strobe = 1'b1, sel_n = 1'b1, addr_enable = 1'b1;
    logic kbd_clock_phase, kbd_clock_half, rom_clock_cmd_select_n;
    logic bus_reset_out, buffer_out_oe, buffer_out0_inv, smem_read_n;
    logic smem_write_n, smem_oe, sd_oe, kbd_ctrl_select_n, nb_mode;
    logic [3:0] req_mux;
    logic [6:0] dack_n;
    logic [7:0] buffer_out, sd_out, clock_addr;
    int n_errors = 0, cmp_count = 0;
    localparam int LN [16] = '{0,0,0,0,1,1,2,1,2,3,3,2,3,3,2,1};
    always #10 clk = ~clk;
    ibrm_chipset_model ibrm_chipset_model_inst (.clk, .nrst, .slot_cmd,
        .ack_cmd, .kbd_clock_phase, .kbd_clock_half, .encoded_ack_code,
        .rom_clock_cmd_select_n);
    ibrm_top ibrm_top_inst (.clk, .nrst, .bus_reset_out, .irq_a, .irq_b,
        .rtc_irq_n, .irq15, .dma_req, .kbd_clock_phase, .kbd_clock_half,
        .req_mux,
        .encoded_ack_code, .dack_n, .buffer_in, .buffer_out, .buffer_out_oe,
        .buffer_out0_inv, .buffer_float_n, .buffer_latch, .rom_select_n,
        .rom_clock_cmd_select_n, .atbus_float_n, .atbus_cycle_flag(cyc),
        .mem_read_n, .mem_write_n, .smem_read_n, .smem_write_n, .smem_oe,
        .sd_in, .sd_out, .sd_oe, .peripheral_data_bus_in(xd),
        .peripheral_data_bus_out(), .peripheral_data_bus_oe(),
        .clock_addr_strobe(strobe), .clock_addr,
        .dram_we_or_kbd_select_n(sel_n), .addr_enable, .kbd_ctrl_select_n,
        .nb_mode);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wrap_up;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic sweep(output int c[4]);
        c = '{0, 0, 0, 0};
        for (int s = 0; s < 4; s++) begin
            @(posedge clk) slot_cmd <= 2'(s);
            tick(3);
            for (int l = 0; l < 4; l++) c[l] += int'(req_mux[l] === 1'b1);
        end
    endtask : sweep
    task automatic t_mux;
        int b[4], c[4];
        sweep(b);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) begin
                {irq15, dma_req, irq_b, irq_a} <= 15'(16'h0001 << i);
                rtc_irq_n <= (i != 15);
            end
            sweep(c);
            for (int l = 0; l < 4; l++)
                chk(8'(c[l]-b[l]), 8'(LN[i]==l));
        end
        @(posedge clk) begin
            {irq15, dma_req, irq_b, irq_a} <= 15'h0000;
            rtc_irq_n <= 1'b1;
        end
    endtask : t_mux
    task automatic t_ack;
        logic [6:0] e;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk) ack_cmd <= 3'(k);
            tick(3);
            e = (k == 4) ? 7'h7f : ~(7'h01 << (k < 4 ? k : k - 1));
            chk({1'b0, dack_n}, {1'b0, e});
        end
    endtask : t_ack
    task automatic t_io;
        @(posedge clk) buffer_in <= 8'h01;
        tick(3);
        chk(buffer_out, 8'h01);
        chk({7'h00, buffer_out0_inv}, 8'h00);
        @(posedge clk) {buffer_latch, buffer_in} <= {1'b0, 8'ha4};
        tick(3);
        chk(buffer_out, 8'h01);
        chk({7'h00, buffer_out0_inv}, 8'h00);
        @(posedge clk) buffer_latch <= 1'b1;
        tick(2);
        chk(buffer_out, 8'ha4);
        chk({7'h00, buffer_out0_inv}, 8'h01);
        @(posedge clk) buffer_float_n <= 1'b0;
        tick(2);
        chk({7'h00, buffer_out_oe}, 8'h00);
        @(posedge clk) {rom_select_n, xd, mem_read_n} <= {1'b0, 8'hc3, 1'b0};
        tick(3);
        chk({7'h00, sd_oe}, 8'h01);
        chk(sd_out, 8'hc3);
        chk({6'h00, smem_read_n, smem_write_n}, 8'h01);
        @(posedge clk) {atbus_float_n, mem_read_n, mem_write_n} <= 3'h2;
        tick(2);
        chk({6'h00, sd_oe, smem_oe}, 8'h00);
        chk({6'h00, smem_read_n, smem_write_n}, 8'h02);
        @(posedge clk) {atbus_float_n, rom_select_n} <= 2'h3;
        tick(2);
        chk({6'h00, sd_oe, smem_oe}, 8'h01);
    endtask : t_io
    task automatic t_addr;
        @(posedge clk) {strobe, xd} <= {1'b1, 8'h3c};
        tick(2);
        @(posedge clk) strobe <= 1'b0;
        tick(2);
        chk(clock_addr, 8'h3c);
        @(posedge clk) xd <= 8'h99;
        tick(2);
        chk(clock_addr, 8'h3c);
    endtask : t_addr
    task automatic t_kbd;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) {sel_n, addr_enable} <= 2'(k);
            tick(3);
            chk({7'h00, kbd_ctrl_select_n}, 8'(k != 0));
        end
    endtask : t_kbd
    task automatic t_strap;
        @(posedge clk) {nrst, xd} <= {1'b0, 8'h12};
        tick(3);
        chk({7'h00, bus_reset_out}, 8'h01);
        chk({1'b0, dack_n}, 8'h7f);
        @(posedge clk) nrst <= 1'b1;
        tick(2);
        chk({7'h00, nb_mode}, 8'h00);
    endtask : t_strap
    initial begin
        tick(20);
        chk({7'h00, bus_reset_out}, 8'h01);
        @(posedge clk) nrst <= 1'b1;
        tick(2);
        chk({7'h00, bus_reset_out}, 8'h00);
        chk({7'h00, nb_mode}, 8'h01);
        t_mux();
        t_ack();
        t_io();
        t_addr();
        t_kbd();
        t_strap();
        wrap_up();
    end
    initial begin
        #100us;
        n_errors++;
        wrap_up();
    end
endmodule : tb
